/* File: common/isb_pkg.sv */
// isb_pkg: constants, types and arithmetic helpers for the filter chain
// assumes one clock at the DAC rate and two's-complement samples
`default_nettype none
package isb_pkg;
  typedef logic signed [15:0] isb_samp_t;
  typedef struct packed {
    logic signed [17:0] re;
    logic signed [17:0] im;
  } isb_cplx_t;

  // configuration register map (byte k of SINC_COEF is register COEF_REG_FIRST + k)
  localparam logic [7:0] COEF_REG_FIRST = 8'h20;
  localparam logic [7:0] COEF_REG_LAST  = 8'h27;
  localparam logic [7:0] MODE_REG_FIRST = 8'h1c;
  localparam logic [7:0] MODE_REG_LAST  = 8'h1e;

  localparam int PATHS      = 2;
  localparam int SINC_TAPS  = 9;
  localparam int SINC_CTR   = 4;
  localparam int SINC_W   [5] = '{3, 4, 5, 7, 10};
  localparam int SINC_LSB [5] = '{0, 6, 14, 24, 38};
  localparam int SINC_SHIFT = 9;
  localparam int HB_TAPS    = 11;
  localparam int HB_ROT_OFS = 3;
  localparam int HB_SHIFT   = 8;
  localparam logic signed [9:0] HB_COEF [11] = '{
    10'sh003, 10'sh000, -10'sh019, 10'sh000, 10'sh096, 10'sh100,
    10'sh096, 10'sh000, -10'sh019, 10'sh000, 10'sh003};
  localparam logic signed [9:0] ROT45 = 10'sh0b5;
  localparam logic [2:0] ANG_NONE    = 3'h0;
  localparam logic [2:0] ANG_QUARTER = 3'h2;
  localparam isb_samp_t  SAMP_RST    = 16'sh0000;
  localparam logic [2:0] CNT_RST     = 3'h0;

  // sign-extend a coefficient field of width w starting at bit lsb
  function automatic logic signed [9:0] coef_field(input logic [63:0] regs,
      input int lsb, input int w);
    logic signed [9:0] r;
    r = '0;
    for (int i = 0; i < 10; i++) begin
      r[i] = regs[lsb + ((i < w) ? i : w - 1)];
    end
    return r;
  endfunction : coef_field

  // round half up, then clamp to the sample range
  function automatic isb_samp_t sat_round(input logic signed [39:0] acc, input int sh);
    logic signed [39:0] r;
    r = (acc + (40'sh1 <<< (sh - 1))) >>> sh;
    if (r > 40'sh7fff) return 16'sh7fff;
    if (r < -40'sh8000) return 16'sh8000;
    return r[15:0];
  endfunction : sat_round

  function automatic isb_samp_t neg_sat(input isb_samp_t x);
    return (x == 16'sh8000) ? 16'sh7fff : -x;
  endfunction : neg_sat

  // one pulse every 2**k clocks
  function automatic logic rate_tick(input logic [2:0] c, input logic [1:0] k);
    case (k)
      2'h0: return 1'b1;
      2'h1: return c[0] == 1'b0;
      2'h2: return c[1:0] == 2'h0;
      default: return c == 3'h0;
    endcase
  endfunction : rate_tick

  // rotate a complex sample by idx * 45 degrees
  function automatic isb_cplx_t rot8(input isb_samp_t re, input isb_samp_t im,
      input logic [2:0] idx);
    logic signed [27:0] pa;
    logic signed [27:0] pb;
    logic signed [17:0] a;
    logic signed [17:0] b;
    isb_cplx_t          r;
    a  = 18'(re);
    b  = 18'(im);
    pa = 28'(a - b) * 28'(ROT45);
    pb = 28'(a + b) * 28'(ROT45);
    if (idx[0]) begin
      a = pa[25:8];
      b = pb[25:8];
    end
    case (idx[2:1])
      2'h0: r = {a, b};
      2'h1: r = {-b, a};
      2'h2: r = {-a, -b};
      default: r = {b, -a};
    endcase
    return r;
  endfunction : rot8
endpackage : isb_pkg
`default_nettype wire

/* File: logic/isb_filter_chain.sv */
// isb_filter_chain: premodulation, inverse sinc and three half-band stages
// assumes configuration ports static while data flows; CLOCK is the DAC rate
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1: inverse sinc built from four real filters combined into complex output
// R2: coefficients come from configuration bytes 0x20..0x27, signed two's complement
// R3: coefficient widths 3, 4, 5, 7, 10 bits for taps zero to four
// R4: nine taps; taps five to eight use conjugates of taps three down to zero
// R5: without interpolation software may load real symmetric 2,-4,10,-35,401
// R6: software keeps inverse sinc centre within 0.4 DAC rate less half bandwidth
// R7: inverse sinc runs at the input rate, pass band 0.8 of it
// R8: three cascadable 2x stages select overall interpolation of two, four or eight
// R9: stage bandwidths 0.8, 0.5, 0.4 of each stage input rate; all three stages here share one HB_COEF set, so one bandwidth
// R10: each stage aims at 0.001 dB ripple, 85 dB image rejection
// R11: first stage four modes, same shape, centre stepped by half input rate
// R12: first stage modes 2 and 3 modulate by input rate, 0 and 1 not
// R13: first stage modes 1 and 3 cross-mix I and Q, 0 and 2 independent
// R14: second stage eight modes, quarter-rate steps, modes 4 to 7 modulate
// R15: second stage modes 0 and 4 independent, all others cross-mix
// R16: software pairs premodulation and first stage modes for 2x centres
// R17: software pairs stage modes and premodulation for 4x centres in eighths
// R18: premodulation multiplies successive input samples by plus and minus one
// R19: real-stream input disables all cross-mixing rotations
// R20: two independent complex paths through the whole chain
// R21: filter outputs rounded and saturated to 16 bits
// R22: coefficient fields packed contiguously in tap order, real before imaginary
module isb_filter_chain
  import isb_pkg::*;
(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST,
  // rate and mode configuration
  input  wire logic [1:0]  INTERP_SEL,
  input  wire logic        PREMOD_EN,
  input  wire logic        SINC_EN,
  input  wire logic        REAL_INPUT,
  input  wire logic [1:0]  FIRST_STAGE_MODE,
  input  wire logic [2:0]  SECOND_STAGE_MODE,
  input  wire logic [2:0]  THIRD_STAGE_MODE,
  // inverse sinc coefficient bytes
  input  wire logic [63:0] SINC_COEF,
  // input samples, path 0 and path 1
  input  wire isb_samp_t   IN_I0,
  input  wire isb_samp_t   IN_Q0,
  input  wire isb_samp_t   IN_I1,
  input  wire isb_samp_t   IN_Q1,
  output logic             IN_TAKE,
  // output samples at the DAC rate
  output logic             OUT_VALID,
  output isb_samp_t        OUT_I0,
  output isb_samp_t        OUT_Q0,
  output isb_samp_t        OUT_I1,
  output isb_samp_t        OUT_Q1
);
  logic [2:0]         cnt_q, cnt_d;
  logic               take_q, take_d;
  logic               vld_q, vld_d;
  logic               in_tick;
  logic               tick1;
  logic               tick2;
  logic               tick3;
  logic [2:0]         ang1, ang2, ang3;
  logic               mod1, mod2, mod3;
  logic               psgn_q, psgn_d;
  isb_samp_t          in_i  [PATHS];
  isb_samp_t          in_q  [PATHS];
  isb_samp_t          pi_q  [PATHS];
  isb_samp_t          pq_q  [PATHS];
  isb_samp_t          pi_d  [PATHS];
  isb_samp_t          pq_d  [PATHS];
  isb_samp_t          xi_q  [PATHS][SINC_TAPS];
  isb_samp_t          xq_q  [PATHS][SINC_TAPS];
  isb_samp_t          xi_d  [PATHS][SINC_TAPS];
  isb_samp_t          xq_d  [PATHS][SINC_TAPS];
  isb_samp_t          si_q  [PATHS];
  isb_samp_t          sq_q  [PATHS];
  isb_samp_t          si_d  [PATHS];
  isb_samp_t          sq_d  [PATHS];
  logic signed [10:0] cre   [SINC_TAPS];
  logic signed [10:0] cim   [SINC_TAPS];
  isb_samp_t          h1i   [PATHS];
  isb_samp_t          h1q   [PATHS];
  isb_samp_t          h2i   [PATHS];
  isb_samp_t          h2q   [PATHS];
  isb_samp_t          h3i   [PATHS];
  isb_samp_t          h3q   [PATHS];
  isb_samp_t          oi_q  [PATHS];
  isb_samp_t          oq_q  [PATHS];
  isb_samp_t          oi_d  [PATHS];
  isb_samp_t          oq_d  [PATHS];

  assign in_i[0] = IN_I0;
  assign in_q[0] = IN_Q0;
  assign in_i[1] = IN_I1;
  assign in_q[1] = IN_Q1;

  // rate divider: input and stage enables
  always_comb begin
    cnt_d  = cnt_q + 3'h1;
    take_d = rate_tick(cnt_d, INTERP_SEL); // R8
    vld_d  = 1'b1;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      cnt_q  <= CNT_RST;
      take_q <= 1'b0;
      vld_q  <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      take_q <= take_d;
      vld_q  <= vld_d;
    end
  end

  assign in_tick = take_q;
  assign tick1   = (INTERP_SEL > 2'h0) && rate_tick(cnt_q, INTERP_SEL - 2'h1); // R8
  assign tick2   = (INTERP_SEL > 2'h1) && rate_tick(cnt_q, INTERP_SEL - 2'h2); // R8
  assign tick3   = (INTERP_SEL > 2'h2) && rate_tick(cnt_q, INTERP_SEL - 2'h3); // R8

  // stage mode decode
  always_comb begin
    ang1 = (FIRST_STAGE_MODE[0] && !REAL_INPUT) ? ANG_QUARTER : ANG_NONE; // R11 R13 R19
    mod1 = FIRST_STAGE_MODE[1]; // R12
    ang2 = REAL_INPUT ? ANG_NONE : {1'b0, SECOND_STAGE_MODE[1:0]}; // R15 R19
    mod2 = SECOND_STAGE_MODE[2]; // R14
    ang3 = REAL_INPUT ? ANG_NONE : {1'b0, THIRD_STAGE_MODE[1:0]}; // R19
    mod3 = THIRD_STAGE_MODE[2];
  end

  // coefficient unpack with conjugate upper half
  always_comb begin
    for (int k = 0; k <= SINC_CTR; k++) begin
      cre[k] = 11'(coef_field(SINC_COEF, SINC_LSB[k], SINC_W[k])); // R2 R3 R22
      cim[k] = 11'(coef_field(SINC_COEF, SINC_LSB[k] + SINC_W[k], SINC_W[k])); // R2 R3 R22
    end
    for (int k = SINC_CTR + 1; k < SINC_TAPS; k++) begin
      cre[k] = cre[SINC_TAPS - 1 - k]; // R4
      cim[k] = -cim[SINC_TAPS - 1 - k]; // R4
    end
  end

  // premodulation and inverse sinc at the input rate
  always_comb begin
    logic signed [39:0] a_ii;
    logic signed [39:0] a_qq;
    logic signed [39:0] a_iq;
    logic signed [39:0] a_qi;
    a_ii = '0;
    a_qq = '0;
    a_iq = '0;
    a_qi = '0;
    psgn_d = in_tick ? ~psgn_q : psgn_q; // R18
    for (int p = 0; p < PATHS; p++) begin
      pi_d[p] = pi_q[p];
      pq_d[p] = pq_q[p];
      xi_d[p] = xi_q[p];
      xq_d[p] = xq_q[p];
      si_d[p] = si_q[p];
      sq_d[p] = sq_q[p];
      if (in_tick) begin
        pi_d[p] = (PREMOD_EN && psgn_q) ? neg_sat(in_i[p]) : in_i[p]; // R18
        pq_d[p] = (PREMOD_EN && psgn_q) ? neg_sat(in_q[p]) : in_q[p]; // R18
        for (int k = SINC_TAPS - 1; k > 0; k--) begin
          xi_d[p][k] = xi_q[p][k - 1]; // R7
          xq_d[p][k] = xq_q[p][k - 1]; // R7
        end
        xi_d[p][0] = pi_q[p];
        xq_d[p][0] = pq_q[p];
        a_ii = '0;
        a_qq = '0;
        a_iq = '0;
        a_qi = '0;
        for (int k = 0; k < SINC_TAPS; k++) begin
          a_ii = a_ii + 40'(cre[k]) * 40'(xi_d[p][k]); // R1
          a_qq = a_qq + 40'(cim[k]) * 40'(xq_d[p][k]); // R1
          a_iq = a_iq + 40'(cre[k]) * 40'(xq_d[p][k]); // R1
          a_qi = a_qi + 40'(cim[k]) * 40'(xi_d[p][k]); // R1
        end
        if (SINC_EN) begin
          si_d[p] = sat_round(a_ii - a_qq, SINC_SHIFT); // R1 R21
          sq_d[p] = sat_round(a_iq + a_qi, SINC_SHIFT); // R1 R21
        end else begin
          si_d[p] = xi_d[p][SINC_CTR];
          sq_d[p] = xq_d[p][SINC_CTR];
        end
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      psgn_q <= 1'b0;
      for (int p = 0; p < PATHS; p++) begin
        pi_q[p] <= SAMP_RST;
        pq_q[p] <= SAMP_RST;
        si_q[p] <= SAMP_RST;
        sq_q[p] <= SAMP_RST;
        for (int k = 0; k < SINC_TAPS; k++) begin
          xi_q[p][k] <= SAMP_RST;
          xq_q[p][k] <= SAMP_RST;
        end
      end
    end else begin
      psgn_q <= psgn_d;
      pi_q   <= pi_d;
      pq_q   <= pq_d;
      si_q   <= si_d;
      sq_q   <= sq_d;
      xi_q   <= xi_d;
      xq_q   <= xq_d;
    end
  end

  // half-band cascade, one per path
  for (genvar p = 0; p < PATHS; p++) begin : g_path // R20
    isb_halfband u_first (
      .clk      (CLOCK),
      .rst      (RST),
      .in_tick  (in_tick),
      .out_tick (tick1),
      .ang      (ang1),
      .modu     (mod1),
      .in_i     (si_q[p]),
      .in_q     (sq_q[p]),
      .out_sgn  (),
      .out_i    (h1i[p]),
      .out_q    (h1q[p])
    );
    isb_halfband u_second (
      .clk      (CLOCK),
      .rst      (RST),
      .in_tick  (tick1),
      .out_tick (tick2),
      .ang      (ang2),
      .modu     (mod2),
      .in_i     (h1i[p]),
      .in_q     (h1q[p]),
      .out_sgn  (),
      .out_i    (h2i[p]),
      .out_q    (h2q[p])
    );
    isb_halfband u_third (
      .clk      (CLOCK),
      .rst      (RST),
      .in_tick  (tick2),
      .out_tick (tick3),
      .ang      (ang3),
      .modu     (mod3),
      .in_i     (h2i[p]),
      .in_q     (h2q[p]),
      .out_sgn  (),
      .out_i    (h3i[p]),
      .out_q    (h3q[p])
    );
  end

  // output select by interpolation factor
  always_comb begin
    for (int p = 0; p < PATHS; p++) begin
      case (INTERP_SEL) // R8
        2'h0: begin
          oi_d[p] = si_q[p];
          oq_d[p] = sq_q[p];
        end
        2'h1: begin
          oi_d[p] = h1i[p];
          oq_d[p] = h1q[p];
        end
        2'h2: begin
          oi_d[p] = h2i[p];
          oq_d[p] = h2q[p];
        end
        default: begin
          oi_d[p] = h3i[p];
          oq_d[p] = h3q[p];
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      for (int p = 0; p < PATHS; p++) begin
        oi_q[p] <= SAMP_RST;
        oq_q[p] <= SAMP_RST;
      end
    end else begin
      oi_q <= oi_d;
      oq_q <= oq_d;
    end
  end

  assign IN_TAKE   = take_q;
  assign OUT_VALID = vld_q;
  assign OUT_I0    = oi_q[0];
  assign OUT_Q0    = oq_q[0];
  assign OUT_I1    = oi_q[1];
  assign OUT_Q1    = oq_q[1];

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence s_gap8;
    !IN_TAKE [*7] ##1 IN_TAKE;
  endsequence

  a_take_rate8: assert property (IN_TAKE && INTERP_SEL == 2'h3 |=> s_gap8) // R8
    else $error("input rate is not one eighth in 8x mode");
  a_premod_pass: assert property (in_tick && !(PREMOD_EN && psgn_q) // R18
      |=> pi_q[0] == $past(IN_I0))
    else $error("premodulation altered a pass sample");
  a_premod_flip: assert property (in_tick && PREMOD_EN && psgn_q && IN_I0 != 16'sh8000 // R18
      |=> pi_q[0] == -$past(IN_I0))
    else $error("premodulation did not negate the sample");
  a_real_nomix: assert property (REAL_INPUT |-> ang1 == 3'h0 && ang2 == 3'h0 && ang3 == 3'h0) // R19
    else $error("cross-mixing active on real input");
  a_first_mode: assert property (!REAL_INPUT // R12 R13
      |-> (ang1 == ANG_QUARTER) == FIRST_STAGE_MODE[0] && mod1 == FIRST_STAGE_MODE[1])
    else $error("first stage mode decode wrong");
  a_second_mode: assert property (!REAL_INPUT // R14 R15
      |-> (ang2 == 3'h0) == (SECOND_STAGE_MODE[1:0] == 2'h0) && mod2 == SECOND_STAGE_MODE[2])
    else $error("second stage mode decode wrong");
  a_conj_taps: assert property (cre[8] == 11'($signed(SINC_COEF[SINC_LSB[0] +: SINC_W[0]])) // R4
      && cim[8] == -11'($signed(SINC_COEF[SINC_LSB[0] + SINC_W[0] +: SINC_W[0]]))
      && cim[5] == -11'($signed(SINC_COEF[SINC_LSB[3] + SINC_W[3] +: SINC_W[3]])))
    else $error("upper taps are not conjugates of the coefficient fields");
  a_sinc_bypass: assert property (!SINC_EN && in_tick |=> si_q[1] == $past(xi_q[1][3])) // R7
    else $error("bypass does not take the centre delay");
  a_out_follow: assert property (INTERP_SEL == 2'h1 ##1 INTERP_SEL == 2'h1 // R8
      |-> OUT_Q1 == $past(h1q[1]))
    else $error("2x output does not follow first stage");
endmodule : isb_filter_chain
`default_nettype wire

/* File: logic/isb_halfband.sv */
// isb_halfband: one 2x half-band interpolator with rotated pass band
// assumes every in_tick coincides with an out_tick
`timescale 1ns/1ps
`default_nettype none
module isb_halfband
  import isb_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // rate enables
  input  wire logic       in_tick,
  input  wire logic       out_tick,
  // per-tap rotation and output modulation
  input  wire logic [2:0] ang,
  input  wire logic       modu,
  // samples
  input  wire isb_samp_t  in_i,
  input  wire isb_samp_t  in_q,
  output logic            out_sgn,
  output isb_samp_t       out_i,
  output isb_samp_t       out_q
);
  isb_samp_t dli_q [HB_TAPS];
  isb_samp_t dlq_q [HB_TAPS];
  isb_samp_t dli_d [HB_TAPS];
  isb_samp_t dlq_d [HB_TAPS];
  isb_samp_t oi_q, oq_q, oi_d, oq_d;
  logic      sgn_q, sgn_d;

  always_comb begin
    logic signed [39:0] ai;
    logic signed [39:0] aq;
    isb_cplx_t          t;
    isb_samp_t          fi;
    isb_samp_t          fq;
    ai = '0;
    aq = '0;
    t  = '0;
    fi = SAMP_RST;
    fq = SAMP_RST;
    dli_d = dli_q;
    dlq_d = dlq_q;
    oi_d  = oi_q;
    oq_d  = oq_q;
    sgn_d = sgn_q;
    if (out_tick) begin
      for (int k = HB_TAPS - 1; k > 0; k--) begin
        dli_d[k] = dli_q[k - 1];
        dlq_d[k] = dlq_q[k - 1];
      end
      dli_d[0] = in_tick ? in_i : SAMP_RST; // R8
      dlq_d[0] = in_tick ? in_q : SAMP_RST; // R8
      for (int k = 0; k < HB_TAPS; k++) begin
        t  = rot8(dli_d[k], dlq_d[k], 3'(ang * 3'(k + HB_ROT_OFS))); // R11
        ai = ai + 40'(HB_COEF[k]) * 40'(t.re); // R9 R10
        aq = aq + 40'(HB_COEF[k]) * 40'(t.im); // R9 R10
      end
      fi = sat_round(ai, HB_SHIFT); // R21
      fq = sat_round(aq, HB_SHIFT); // R21
      if (modu && sgn_q) begin
        fi = neg_sat(fi); // R12 R14
        fq = neg_sat(fq); // R12 R14
      end
      oi_d  = fi;
      oq_d  = fq;
      sgn_d = ~sgn_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < HB_TAPS; k++) begin
        dli_q[k] <= SAMP_RST;
        dlq_q[k] <= SAMP_RST;
      end
      oi_q  <= SAMP_RST;
      oq_q  <= SAMP_RST;
      sgn_q <= 1'b0;
    end else begin
      dli_q <= dli_d;
      dlq_q <= dlq_d;
      oi_q  <= oi_d;
      oq_q  <= oq_d;
      sgn_q <= sgn_d;
    end
  end

  assign out_i   = oi_q;
  assign out_q   = oq_q;
  assign out_sgn = sgn_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_zero_stuff: assert property (out_tick && !in_tick |=> dli_q[0] == SAMP_RST) // R8
    else $error("zero not stuffed between input samples");
  a_mod_phase: assert property (out_tick |=> sgn_q != $past(sgn_q)) // R12
    else $error("modulation sign did not alternate");
  a_idle_hold: assert property (!out_tick |=> $stable(oi_q) && $stable(oq_q)) // R8
    else $error("stage output moved without its rate tick");
endmodule : isb_halfband
`default_nettype wire

/* File: test/isb_source_model.sv */
// isb_source_model: upstream sample source feeding the filter chain
// assumes bench values are steady across each rising edge
`timescale 1ns/1ps
`default_nettype none
module isb_source_model
  import isb_pkg::*;
(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      rst,
  // wanted values and take strobe
  input  wire isb_samp_t val [4],
  input  wire logic      take,
  // samples toward the chain
  output isb_samp_t      smp [4]
);
  isb_samp_t hold [4];

  always @(posedge clk) begin
    hold <= val;
  end

  // i and q of both paths change together; outside a take show the inverse
  always @(negedge clk or posedge rst) begin
    for (int k = 0; k < 4; k++) begin
      if (rst) begin
        smp[k] <= SAMP_RST;
      end else begin
        smp[k] <= take ? hold[k] : ~hold[k];
      end
    end
  end
endmodule : isb_source_model
`default_nettype wire

/* File: test/test_isb_filter_chain.sv */
// test_isb_filter_chain: self-checking bench for the filter chain
// assumes the source model upstream and CLOCK at 250 MHz
`timescale 1ns/1ps
`default_nettype none
module test_isb_filter_chain
  import isb_pkg::*;
;
  logic        clock;
  logic        rst;
  logic [1:0]  interp;
  logic        premod;
  logic        sinc_en;
  logic        real_in;
  logic [1:0]  mode1;
  logic [2:0]  mode2;
  logic [2:0]  mode3;
  logic [63:0] coef;
  logic        take;
  logic        ovalid;
  isb_samp_t   val [4];
  isb_samp_t   smp [4];
  isb_samp_t   o [4];
  int          bad_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  isb_filter_chain isb_filter_chain_i (
    .CLOCK(clock), .RST(rst), .INTERP_SEL(interp), .PREMOD_EN(premod),
    .SINC_EN(sinc_en), .REAL_INPUT(real_in), .FIRST_STAGE_MODE(mode1),
    .SECOND_STAGE_MODE(mode2), .THIRD_STAGE_MODE(mode3), .SINC_COEF(coef),
    .IN_I0(smp[0]), .IN_Q0(smp[1]), .IN_I1(smp[2]), .IN_Q1(smp[3]), .IN_TAKE(take),
    .OUT_VALID(ovalid), .OUT_I0(o[0]), .OUT_Q0(o[1]), .OUT_I1(o[2]), .OUT_Q1(o[3]));

  isb_source_model isb_source_model_i (
    .clk(clock), .rst(rst), .val(val), .take(take), .smp(smp));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic cmp_samp(input string what, input isb_samp_t exp, input isb_samp_t got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_samp

  task automatic cmp_flag(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_flag

  task automatic cmp_count(input string what, input int exp, input int got);
    check_count++;
    if (got != exp) begin
      bad_count++;
      $display("FAIL %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_count

  task automatic put(input isb_samp_t a, input isb_samp_t b, input isb_samp_t c,
      input isb_samp_t d);
    val[0] = a;
    val[1] = b;
    val[2] = c;
    val[3] = d;
  endtask : put

  // pack real then imaginary field of each tap, contiguous in tap order
  task automatic load(input isb_samp_t cr [5], input isb_samp_t ci [5]);
    coef = '0;
    for (int k = 0; k < 5; k++) begin
      coef |= (64'(cr[k]) & ((64'h1 << SINC_W[k]) - 64'h1)) << SINC_LSB[k];
      coef |= (64'(ci[k]) & ((64'h1 << SINC_W[k]) - 64'h1)) << (SINC_LSB[k] + SINC_W[k]);
    end
  endtask : load

  task automatic do_reset();
    put(SAMP_RST, SAMP_RST, SAMP_RST, SAMP_RST);
    rst = 1'b1;
    repeat (4) @(negedge clock);
    cmp_flag("valid in reset", 1'b0, ovalid);
    cmp_samp("out in reset", SAMP_RST, o[0]);
    rst = 1'b0;
    @(negedge clock);
    cmp_flag("valid after reset", 1'b1, ovalid);
    cmp_flag("take after reset", interp == 2'h0, take);
  endtask : do_reset

  // impulse 512 on i of path 0 and q of path 1 shows every tap
  task automatic sinc_impulse();
    isb_samp_t cr [5] = '{-16'sh0004, 16'sh0007, -16'sh0010, 16'sh003f, -16'sh0200};
    isb_samp_t ci [5] = '{16'sh0003, -16'sh0008, 16'sh000f, -16'sh0040, 16'sh01ff};
    isb_samp_t im;
    int        k;
    int        n;
    load(cr, ci);
    interp = 2'h0;
    sinc_en = 1'b1;
    do_reset();
    put(16'sh0200, 16'sh0000, 16'sh0000, 16'sh0200);
    @(negedge clock);
    put(16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000);
    n = 0;
    while (o[0] === 16'sh0000 && n < 20) begin
      @(negedge clock);
      n++;
    end
    for (n = 0; n < 9; n++) begin
      k = (n <= 4) ? n : 8 - n;
      im = (n > 4) ? -ci[k] : ci[k];
      cmp_samp("sinc i0", cr[k], o[0]);
      cmp_samp("sinc q0", im, o[1]);
      cmp_samp("sinc i1", -im, o[2]);
      cmp_samp("sinc q1", cr[k], o[3]);
      @(negedge clock);
    end
    cmp_samp("sinc tail", 16'sh0000, o[0]);
  endtask : sinc_impulse

  // alternating input through the plain real set gives +-503
  task automatic premod_check();
    isb_samp_t cr [5] = '{16'sh0002, -16'sh0004, 16'sh000a, -16'sh0023, 16'sh0191};
    isb_samp_t ci [5] = '{16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000};
    isb_samp_t a;
    load(cr, ci);
    interp = 2'h0;
    premod = 1'b1;
    sinc_en = 1'b1;
    do_reset();
    put(16'sh0200, 16'sh0000, 16'sh0200, 16'sh0000);
    repeat (30) @(negedge clock);
    a = o[0];
    cmp_samp("premod mag", 16'sh01f7, (a < 0) ? -a : a);
    @(negedge clock);
    cmp_samp("premod sign", -a, o[0]);
    cmp_samp("premod path1", -a, o[2]);
    cmp_samp("premod q", 16'sh0000, o[1]);
    premod = 1'b0;
  endtask : premod_check

  task automatic sat_check();
    isb_samp_t cr [5] = '{16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000, -16'sh0200};
    isb_samp_t ci [5] = '{16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000, 16'sh0000};
    load(cr, ci);
    interp = 2'h0;
    sinc_en = 1'b1;
    do_reset();
    put(16'sh8000, 16'sh0000, 16'sh0005, 16'sh0000);
    repeat (20) @(negedge clock);
    cmp_samp("saturated", 16'sh7fff, o[0]);
    cmp_samp("small", -16'sh0005, o[2]);
    cmp_samp("sat q", 16'sh0000, o[1]);
  endtask : sat_check

  // step on i0 and q1; watch cross-mixing, modulation and take rate
  task automatic run_mode(input logic [1:0] sel, input logic pm, input logic [1:0] m1,
      input logic [2:0] m2, input logic [2:0] m3, input logic ri, input logic mix,
      input logic md);
    logic      seen;
    isb_samp_t a;
    int        takes;
    interp = sel;
    premod = pm;
    mode1 = m1;
    mode2 = m2;
    mode3 = m3;
    real_in = ri;
    sinc_en = 1'b0;
    do_reset();
    put(16'sh1f40, 16'sh0000, 16'sh0000, 16'sh1f40);
    seen = 1'b0;
    takes = 0;
    repeat (256) begin
      @(negedge clock);
      if (o[1] !== 16'sh0000 || o[2] !== 16'sh0000) seen = 1'b1;
      if (take === 1'b1) takes++;
    end
    if (!mix) begin
      a = o[0];
      @(negedge clock);
      cmp_samp("magnitude", 16'sh1f40, (a < 0) ? -a : a);
      cmp_samp("next sample", md ? -a : a, o[0]);
    end
    cmp_flag("mixing", mix, seen);
    cmp_count("takes", 256 >> sel, takes);
  endtask : run_mode

  initial begin
    rst = 1'b1;
    interp = 2'h0;
    premod = 1'b0;
    sinc_en = 1'b0;
    real_in = 1'b0;
    mode1 = 2'h0;
    mode2 = 3'h0;
    mode3 = 3'h0;
    coef = '0;
    val = '{default: 16'sh0000};
    sinc_impulse();
    premod_check();
    sat_check();
    for (int m = 0; m < 4; m++) begin
      run_mode(2'h1, m[0], m[1:0], 3'h0, 3'h0, 1'b0, m[0], m[1]);
    end
    for (int m = 0; m < 8; m++) begin
      run_mode(2'h2, m[0], m[1:0], m[2:0], 3'h0, 1'b0, m[1:0] != 0, m[2]);
    end
    for (int m = 0; m < 8; m++) begin
      run_mode(2'h3, 1'b0, 2'h0, 3'h0, m[2:0], 1'b0, m[1:0] != 0, m[2]);
    end
    run_mode(2'h0, 1'b0, 2'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0);
    run_mode(2'h1, 1'b0, 2'h3, 3'h0, 3'h0, 1'b1, 1'b0, 1'b1);
    run_mode(2'h2, 1'b0, 2'h0, 3'h5, 3'h0, 1'b1, 1'b0, 1'b1);
    run_mode(2'h3, 1'b0, 2'h0, 3'h0, 3'h6, 1'b1, 1'b0, 1'b1);
    stop_test();
  end
endmodule : test_isb_filter_chain
`default_nettype wire
